// ===== isw_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef ISW_MAP_SVH
`define ISW_MAP_SVH
`define ISW_OFS_EDGE_SEL 8'he6
`define ISW_OFS_PIN_FUNC 8'he7
`define ISW_OFS_IRQ_ENABLE 8'he8
`define ISW_OFS_IRQ_FLAG 8'he9
`define ISW_OFS_SLEEP_CTRL 8'hea
`define ISW_OFS_STATUS 8'heb
`define ISW_OFS_WAKE_PRESCALE 8'hec
`define ISW_RST_EDGE_SEL 8'h00
`define ISW_RST_PIN_FUNC 8'h00
`define ISW_RST_IRQ_ENABLE 16'h0000
`define ISW_RST_PRESCALE 8'h00
`define ISW_SLEEP_BIT 0
`define ISW_PSW_BREAK_BIT 4
`define ISW_PSW_IFLAG_BIT 2
`define ISW_ACCEPT_CYCLES 4'd8
`define ISW_MACHINE_DIV 4'd4
`define ISW_STACK_PUSHES 2'd3
`define ISW_VECTOR_BASE 16'hffe0
`define ISW_BREAK_VECTOR 16'hffde
`endif

// ===== isw_pkg.sv
// Types shared by the interrupt sequencer files.
package isw_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_WAIT_END = 3'b001,
    ST_ACCEPT = 3'b010,
    ST_SLEEP = 3'b011,
    ST_WAKE = 3'b100
  } isw_state_t;

  typedef struct packed {
    logic push_valid;
    logic [1:0] push_index;
    logic [7:0] push_data;
    logic load_pc;
    logic [15:0] vector_addr;
    logic halt;
    logic resume;
  } isw_cpu_cmd_t;
endpackage

// ===== isw_edge_detect.sv
// Edge detector for one external interrupt pin.
`timescale 1ns/1ps
module isw_edge_detect
(
  input wire logic clk, // System clock.
  input wire logic rst, // Asynchronous reset.
  input wire logic tick, // Machine cycle enable.
  input wire logic pin, // Pin level.
  input wire logic enable, // Pin works as an interrupt input.
  input wire logic [1:0] mode, // 01 rising, 10 falling, 11 both.
  output logic edge_seen // Edge found this machine cycle.
);
  logic prev_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prev_reg <= 1'b0;
    else if (tick)
      prev_reg <= pin;
  end

  always_comb
  begin
    edge_seen = tick && enable &&
      ((mode[0] && pin && !prev_reg) || (mode[1] && !pin && prev_reg));
  end
endmodule

// ===== isw_wake_timer.sv
// Wake-up interval counter that runs from 00 to ff before release.
`timescale 1ns/1ps
module isw_wake_timer
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk, // System clock.
  input wire logic rst, // Asynchronous reset.
  input wire logic start, // Clear and begin counting.
  input wire logic [7:0] prescale, // Divider value minus one.
  output logic overflow // One-cycle pulse at count wrap.
);
  logic [7:0] pre_reg;
  logic [WIDTH-1:0] cnt_reg;
  logic run_reg;
  logic step;

  assign step = run_reg && (pre_reg == prescale);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pre_reg <= 8'h00;
    else if (start || step)
      pre_reg <= 8'h00;
    else if (run_reg)
      pre_reg <= pre_reg + 8'h01;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end
    else if (start)
    begin
      cnt_reg <= '0;
      run_reg <= 1'b1;
    end
    else if (step)
    begin
      cnt_reg <= cnt_reg + 1'b1;
      if (&cnt_reg)
        run_reg <= 1'b0;
    end
  end

  assign overflow = step && (&cnt_reg);
endmodule

// ===== isw_sequencer.sv
// Interrupt latch, priority, acceptance sequence and sleep control.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "isw_map.svh"
module isw_sequencer
#(
  parameter int NSRC = 13
)
(
  input wire logic clk, // 250 MHz system clock.
  input wire logic rst, // Asynchronous reset.
  input wire logic [7:0] addr, // Register address.
  input wire logic [7:0] wdata, // Register write data.
  input wire logic wr, // Register write strobe.
  input wire logic rd, // Register read strobe.
  output logic [7:0] rdata, // Read data, cycle after rd.
  input wire logic ext_irq_pin_a, // External interrupt pin a.
  input wire logic ext_irq_pin_b, // External interrupt pin b.
  input wire logic [NSRC-3:0] periph_req, // Peripheral request pulses.
  input wire logic nmi_req, // Non-maskable request pulse.
  input wire logic instr_done, // Current instruction completed.
  input wire logic software_break, // Break instruction executed.
  input wire logic return_from_interrupt, // Return instruction executed.
  input wire logic enable_interrupts_op, // Sets master enable.
  input wire logic disable_interrupts_op, // Clears master enable.
  input wire logic [15:0] pc, // Return program counter.
  input wire logic [7:0] psw_in, // Processor status word.
  output isw_pkg::isw_cpu_cmd_t cmd, // Commands to the CPU core.
  output logic [7:0] processor_status_word, // Status word to push.
  output logic master_enable, // Master interrupt enable.
  output logic in_service // Service task active.
);
  logic [NSRC-1:0] flag_reg;
  logic [NSRC-1:0] flag_set;
  logic [NSRC-1:0] flag_clr;
  logic [15:0] ien_reg;
  logic [7:0] edge_select_register;
  logic [7:0] pin_function_select;
  logic [7:0] prescale_reg;
  logic [7:0] rdata_reg;
  logic iflag_reg;
  logic nmi_pend_reg;
  logic nmi_block_reg;
  logic brk_pend_reg;
  logic svc_reg;
  isw_pkg::isw_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [3:0] div_reg;
  logic tick;
  logic [NSRC-1:0] ready;
  logic [NSRC-1:0] ready_smp_reg;
  logic any_ready;
  logic [3:0] win_idx;
  logic [3:0] sel_reg;
  logic sel_nmi_reg;
  logic sel_brk_reg;
  logic edge_a;
  logic edge_b;
  logic wake_start;
  logic wake_ovf;
  logic sleep_write;
  isw_pkg::isw_cpu_cmd_t cmd_reg;

  // ==========================================================
  // Machine cycle divider and pin edge capture.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_reg <= 4'h0;
    else if (div_reg == `ISW_MACHINE_DIV - 4'd1)
      div_reg <= 4'h0;
    else
      div_reg <= div_reg + 4'd1;
  end
  assign tick = (div_reg == `ISW_MACHINE_DIV - 4'd1);

  isw_edge_detect u_edge_a
  (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .pin(ext_irq_pin_a),
    .enable(pin_function_select[0]),
    .mode(edge_select_register[1:0]),
    .edge_seen(edge_a)
  );

  isw_edge_detect u_edge_b
  (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .pin(ext_irq_pin_b),
    .enable(pin_function_select[1]),
    .mode(edge_select_register[3:2]),
    .edge_seen(edge_b)
  );

  // ==========================================================
  // Request flags. A set in the same cycle as a clear wins, so no
  // event is lost.
  assign flag_set = {periph_req, edge_b, edge_a};

  always_comb
  begin
    flag_clr = '0;
    if (state_reg == isw_pkg::ST_ACCEPT && cnt_reg == 4'd1 &&
        !sel_nmi_reg && !sel_brk_reg)
      flag_clr[sel_reg] = 1'b1;
    if (wr && addr == `ISW_OFS_IRQ_FLAG)
      flag_clr[1:0] = flag_clr[1:0] | ~wdata[1:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_reg <= '0;
    else
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
  end

  // ==========================================================
  // Gating and fixed priority; index zero is highest.
  assign ready = flag_reg & ien_reg[NSRC-1:0] & {NSRC{iflag_reg}};

  // Sampled one machine cycle later so edges get a full cycle to settle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ready_smp_reg <= '0;
    else if (tick)
      ready_smp_reg <= ready;
  end

  function automatic logic [3:0] first_set(input logic [NSRC-1:0] v);
    first_set = 4'd0;
    for (int i = NSRC - 1; i >= 0; i--)
      if (v[i])
        first_set = 4'(i);
  endfunction

  assign win_idx = first_set(ready_smp_reg & ready);
  assign any_ready = |(ready_smp_reg & ready) && !nmi_block_reg;

  // ==========================================================
  // Master enable, break and non-maskable bookkeeping.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      iflag_reg <= 1'b0;
    else if (state_reg == isw_pkg::ST_ACCEPT && cnt_reg == 4'd0 &&
             !sel_nmi_reg)
      iflag_reg <= 1'b0;
    else if (enable_interrupts_op)
      iflag_reg <= 1'b1;
    else if (disable_interrupts_op)
      iflag_reg <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nmi_pend_reg <= 1'b0;
      brk_pend_reg <= 1'b0;
    end
    else
    begin
      if (nmi_req)
        nmi_pend_reg <= 1'b1;
      else if (state_reg == isw_pkg::ST_ACCEPT && sel_nmi_reg)
        nmi_pend_reg <= 1'b0;
      if (software_break)
        brk_pend_reg <= 1'b1;
      else if (state_reg == isw_pkg::ST_ACCEPT && sel_brk_reg)
        brk_pend_reg <= 1'b0;
    end
  end

  // Non-maskable service blocks everything until its return.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      nmi_block_reg <= 1'b0;
    else if (state_reg == isw_pkg::ST_ACCEPT && sel_nmi_reg)
      nmi_block_reg <= 1'b1;
    else if (return_from_interrupt)
      nmi_block_reg <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      svc_reg <= 1'b0;
    else if (state_reg == isw_pkg::ST_ACCEPT)
      svc_reg <= 1'b1;
    else if (return_from_interrupt)
      svc_reg <= 1'b0;
  end

  // ==========================================================
  // Acceptance and sleep state machine.
  assign sleep_write = wr && addr == `ISW_OFS_SLEEP_CTRL &&
    wdata[`ISW_SLEEP_BIT];
  assign wake_start = state_reg == isw_pkg::ST_SLEEP &&
    (|flag_reg || nmi_pend_reg);

  isw_wake_timer #(.WIDTH(8)) u_wake
  (
    .clk(clk),
    .rst(rst),
    .start(wake_start),
    .prescale(prescale_reg),
    .overflow(wake_ovf)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= isw_pkg::ST_RUN;
      cnt_reg <= 4'h0;
      sel_reg <= 4'h0;
      sel_nmi_reg <= 1'b0;
      sel_brk_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        isw_pkg::ST_RUN:
        begin
          if (sleep_write)
            state_reg <= isw_pkg::ST_SLEEP;
          // A break waits while any enabled flag is still being sampled,
          // so a maskable request arriving with it is served first.
          else if ((any_ready || (nmi_pend_reg && !nmi_block_reg) ||
                    (brk_pend_reg && !(|ready))) && !nmi_block_reg)
          begin
            sel_nmi_reg <= nmi_pend_reg;
            sel_brk_reg <= !nmi_pend_reg && !any_ready;
            sel_reg <= win_idx;
            state_reg <= isw_pkg::ST_WAIT_END;
          end
        end
        isw_pkg::ST_WAIT_END:
          if (instr_done)
          begin
            cnt_reg <= 4'h0;
            state_reg <= isw_pkg::ST_ACCEPT;
          end
        isw_pkg::ST_ACCEPT:
          if (cnt_reg == `ISW_ACCEPT_CYCLES - 4'd1)
            state_reg <= isw_pkg::ST_RUN;
          else
            cnt_reg <= cnt_reg + 4'd1;
        isw_pkg::ST_SLEEP:
          if (wake_start)
            state_reg <= isw_pkg::ST_WAKE;
        isw_pkg::ST_WAKE:
          if (wake_ovf)
            state_reg <= isw_pkg::ST_RUN;
        default:
          state_reg <= isw_pkg::ST_RUN;
      endcase
    end
  end

  // ==========================================================
  // CPU command word. Accumulator and index registers are left to
  // software; only return address and status are pushed.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cmd_reg <= '0;
    else
    begin
      cmd_reg.push_valid <= 1'b0;
      cmd_reg.load_pc <= 1'b0;
      cmd_reg.resume <= 1'b0;
      cmd_reg.halt <= state_reg == isw_pkg::ST_SLEEP ||
        state_reg == isw_pkg::ST_WAKE || sleep_write;
      if (state_reg == isw_pkg::ST_ACCEPT &&
          cnt_reg >= 4'd2 && cnt_reg < 4'd2 + 4'(`ISW_STACK_PUSHES))
      begin
        cmd_reg.push_valid <= 1'b1;
        cmd_reg.push_index <= 2'(cnt_reg - 4'd2);
        case (cnt_reg)
          4'd2: cmd_reg.push_data <= pc[15:8];
          4'd3: cmd_reg.push_data <= pc[7:0];
          default: cmd_reg.push_data <= processor_status_word;
        endcase
      end
      if (state_reg == isw_pkg::ST_ACCEPT &&
          cnt_reg == `ISW_ACCEPT_CYCLES - 4'd1)
      begin
        cmd_reg.load_pc <= 1'b1;
        cmd_reg.vector_addr <= sel_brk_reg ? `ISW_BREAK_VECTOR :
          `ISW_VECTOR_BASE - {11'h000, sel_reg, 1'b0};
      end
      if (state_reg == isw_pkg::ST_WAKE && wake_ovf)
        cmd_reg.resume <= 1'b1;
    end
  end

  always_comb
  begin
    processor_status_word = psw_in;
    processor_status_word[`ISW_PSW_BREAK_BIT] = sel_brk_reg;
    processor_status_word[`ISW_PSW_IFLAG_BIT] = iflag_reg;
  end

  assign cmd = cmd_reg;
  assign master_enable = iflag_reg;
  assign in_service = svc_reg;

  // ==========================================================
  // Register port; reads answer one cycle after the strobe.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      edge_select_register <= `ISW_RST_EDGE_SEL;
      pin_function_select <= `ISW_RST_PIN_FUNC;
      ien_reg <= `ISW_RST_IRQ_ENABLE;
      prescale_reg <= `ISW_RST_PRESCALE;
    end
    else if (wr)
    begin
      case (addr)
        `ISW_OFS_EDGE_SEL: edge_select_register <= wdata;
        `ISW_OFS_PIN_FUNC: pin_function_select <= wdata;
        `ISW_OFS_IRQ_ENABLE: ien_reg <= {3'h0, wdata[4:0], wdata};
        `ISW_OFS_WAKE_PRESCALE: prescale_reg <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `ISW_OFS_EDGE_SEL: rdata_reg <= edge_select_register;
        `ISW_OFS_PIN_FUNC: rdata_reg <= pin_function_select;
        `ISW_OFS_IRQ_ENABLE: rdata_reg <= ien_reg[7:0];
        `ISW_OFS_IRQ_FLAG: rdata_reg <= flag_reg[7:0];
        `ISW_OFS_STATUS: rdata_reg <= {3'h0, svc_reg, nmi_block_reg,
          iflag_reg, state_reg == isw_pkg::ST_SLEEP,
          state_reg == isw_pkg::ST_WAKE};
        `ISW_OFS_WAKE_PRESCALE: rdata_reg <= prescale_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end
    else
      rdata_reg <= 8'h00;
  end
  assign rdata = rdata_reg;
endmodule

// ===== isw_core_model.sv
// Core model: retires instructions and takes stack pushes and vector loads.
`timescale 1ns/1ps
module isw_core_model
(
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input isw_pkg::isw_cpu_cmd_t cmd, // Commands from the sequencer.
  output logic instr_done, // Instruction end pulse.
  output logic [23:0] pushed, // Stacked bytes, first push on top.
  output logic [15:0] vec, // Last loaded vector.
  output logic [7:0] n_load // Vector loads seen.
);
  // ====================
  // Core pacing
  logic [3:0] cnt;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 4'h0;
      instr_done <= 1'b0;
      pushed <= 24'h000000;
      vec <= 16'h0000;
      n_load <= 8'h00;
    end
    else
    begin
      // A halted core retires nothing, so no acceptance can start in sleep.
      cnt <= cmd.halt ? cnt : cnt + 4'h1;
      instr_done <= !cmd.halt && cnt == 4'hf;
      if (cmd.push_valid)
        pushed[8*(2-int'(cmd.push_index)) +: 8] <= cmd.push_data;
      if (cmd.load_pc)
      begin
        vec <= cmd.vector_addr;
        n_load <= n_load + 8'h01;
      end
    end
  end
endmodule

// ===== isw_monitor.sv
// Port checker for the interrupt sequencer, bound to its top module.
`timescale 1ns/1ps
`include "isw_map.svh"
module isw_monitor
#(
  parameter int NSRC = 13
)
(
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic [7:0] addr, // Address.
  input wire logic [7:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  input wire logic [7:0] rdata, // Read data.
  input wire logic enable_interrupts_op, // Enable op.
  input wire logic return_from_interrupt, // Return op.
  input wire logic [7:0] psw_in, // Core status.
  input isw_pkg::isw_cpu_cmd_t cmd, // Core commands.
  input wire logic [7:0] processor_status_word, // Status out.
  input wire logic master_enable, // Master enable.
  input wire logic in_service // Service active.
);
  // ====================
  // Checks
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  rd_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not idle");
  push_order_a: assert property (cmd.push_valid && cmd.push_index == 2'd0
    |=> cmd.push_valid && cmd.push_index == 2'd1
    ##1 cmd.push_valid && cmd.push_index == 2'd2)
    else $error("push order wrong");
  push_count_a: assert property (cmd.push_valid && cmd.push_index == 2'd2
    |=> !cmd.push_valid)
    else $error("extra push");
  vector_load_a: assert property (cmd.load_pc |->
    $past(cmd.push_valid, 3) && $past(cmd.push_index, 3) == 2'd2)
    else $error("vector load out of step");
  status_ien_a: assert property (processor_status_word[2] == master_enable)
    else $error("status enable bit wrong");
  status_pass_a: assert property ((processor_status_word & 8'heb) ==
    (psw_in & 8'heb))
    else $error("status bits altered");
  ien_rise_a: assert property ($rose(master_enable) |->
    $past(enable_interrupts_op) || $past(return_from_interrupt))
    else $error("master enable rose alone");
  halt_entry_a: assert property ($rose(cmd.halt) |->
    ($past(wr) && $past(addr) == `ISW_OFS_SLEEP_CTRL) ||
    ($past(wr, 2) && $past(addr, 2) == `ISW_OFS_SLEEP_CTRL))
    else $error("halt without sleep write");
  halt_quiet_a: assert property (cmd.halt && !cmd.resume |->
    !cmd.push_valid && !cmd.load_pc)
    else $error("activity while halted");
  resume_a: assert property (cmd.resume |-> $past(cmd.halt))
    else $error("resume outside sleep");
  svc_end_a: assert property ($fell(in_service) |->
    $past(return_from_interrupt) || $past(return_from_interrupt, 2))
    else $error("service ended without return");
endmodule

bind isw_sequencer isw_monitor #(.NSRC(NSRC)) u_isw_monitor (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .enable_interrupts_op(enable_interrupts_op),
  .return_from_interrupt(return_from_interrupt), .psw_in(psw_in),
  .cmd(cmd), .processor_status_word(processor_status_word),
  .master_enable(master_enable), .in_service(in_service));

// ===== tb.sv
// Self-checking bench for the interrupt sequencer.
`timescale 1ns/1ps
module tb;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;}
    isw_row_t;
  localparam logic [4:0] NMI = 5'h01, SOFTWARE_BREAK = 5'h02, RET = 5'h04;
  localparam logic [4:0] EI = 5'h08, DI = 5'h10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin_a = 1'b0;
  logic [10:0] preq = 11'h000;
  logic [4:0] ev = 5'h00;
  logic [7:0] rdata, psw_out, rd_v, n_load;
  logic me, svc, idone;
  logic [23:0] pushed;
  logic [15:0] vec;
  isw_pkg::isw_cpu_cmd_t cmd;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  isw_row_t rows [7] = '{'{1'b0, 8'he6, 8'h00, 8'h00},
    '{1'b0, 8'he7, 8'h00, 8'h00}, '{1'b0, 8'hec, 8'h00, 8'h00},
    '{1'b1, 8'he6, 8'h0f, 8'h0f}, '{1'b1, 8'he7, 8'h03, 8'h03},
    '{1'b1, 8'hec, 8'h03, 8'h00 + 8'h03}, '{1'b1, 8'h10, 8'ha5, 8'h00}};

  isw_sequencer u_isw_sequencer (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_irq_pin_a(pin_a), .ext_irq_pin_b(1'b0), .periph_req(preq),
    .nmi_req(ev[0]), .instr_done(idone), .software_break(ev[1]),
    .return_from_interrupt(ev[2]), .enable_interrupts_op(ev[3]),
    .disable_interrupts_op(ev[4]), .pc(16'h1234), .psw_in(8'h41),
    .cmd(cmd), .processor_status_word(psw_out), .master_enable(me),
    .in_service(svc));
  isw_core_model u_isw_core_model (.clk(clk), .rst(rst), .cmd(cmd),
    .instr_done(idone), .pushed(pushed), .vec(vec), .n_load(n_load));

  initial
  begin
    forever #2 clk = ~clk;
  end

  // ====================
  // Tasks
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(string nm, logic [23:0] s, logic [23:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pulse(logic [4:0] e, logic [10:0] p);
    @(posedge clk);
    ev <= e;
    preq <= p;
    @(posedge clk);
    ev <= 5'h00;
    preq <= 11'h000;
  endtask
  task automatic done();
    pulse(RET, 11'h000);
    pulse(EI, 11'h000);
  endtask
  task automatic serve(logic [15:0] v, logic [7:0] ps);
    logic [7:0] n0;
    n0 = n_load;
    for (int i = 0; i < 600 && n_load == n0; i++)
      @(posedge clk);
    tick(1);
    chk("vector", vec, v);
    chk("stack", pushed, {8'h12, 8'h34, ps});
  endtask
  task automatic quiet(int n);
    logic [7:0] n0;
    n0 = n_load;
    tick(n);
    chk("idle", n_load, n0);
  endtask
  task automatic wake();
    int i;
    for (i = 0; i < 800 && cmd.halt; i++)
      @(posedge clk);
    chk("wake time", i >= 255, 1);
    chk("halt", cmd.halt, 0);
  endtask
  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // The ceiling sits well above the longest sequence, about 1700 cycles.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      conclude();
    end
  end

  // ====================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    chk("ien", me, 0);
    foreach (rows[i])
    begin
      if (rows[i].w)
        wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, rd_v);
      chk("reg", rd_v, rows[i].e);
    end
    wreg(8'hec, 8'h00);
    wreg(8'he7, 8'h00);
    wreg(8'he8, 8'hff);
    pulse(EI, 11'h001);
    serve(16'hffdc, 8'h41);
    chk("ien", me, 0);
    pulse(5'h00, 11'h002);
    quiet(120);
    done();
    serve(16'hffda, 8'h41);
    done();
    pulse(5'h00, 11'h028);
    serve(16'hffd6, 8'h41);
    done();
    serve(16'hffd2, 8'h41);
    done();
    pulse(SOFTWARE_BREAK, 11'h004);
    serve(16'hffd8, 8'h41);
    done();
    serve(16'hffde, 8'h51);
    done();
    pulse(NMI, 11'h000);
    tick(100);
    pulse(EI, 11'h010);
    quiet(120);
    done();
    serve(16'hffd4, 8'h41);
    done();
    wreg(8'he6, 8'h03);
    pin_a <= 1'b1;
    tick(40);
    pin_a <= 1'b0;
    quiet(80);
    wreg(8'he7, 8'h01);
    for (int m = 1; m < 4; m++)
    begin
      wreg(8'he6, 8'(m));
      for (int k = 0; k < 2; k++)
      begin
        pin_a <= ~pin_a;
        tick(1);
        if (pin_a ? m[0] : m[1])
          serve(16'hffe0, 8'h41);
        else
          quiet(80);
        done();
      end
    end
    wreg(8'hea, 8'h01);
    tick(4);
    chk("halt", cmd.halt, 1);
    pulse(5'h00, 11'h001);
    wake();
    serve(16'hffdc, 8'h41);
    done();
    pulse(DI, 11'h000);
    wreg(8'hea, 8'h01);
    tick(4);
    pulse(5'h00, 11'h002);
    wake();
    quiet(120);
    wreg(8'hea, 8'h01);
    tick(4);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(2);
    chk("halt", cmd.halt, 0);
    rreg(8'he7, rd_v);
    chk("reg", rd_v, 8'h00);
    conclude();
  end
endmodule
